// [src/char_gen_defs.vh]
// Offsets, field positions, reset values and timing counts of the generator
`ifndef CHAR_GEN_DEFS_VH
`define CHAR_GEN_DEFS_VH

// Register byte offsets
`define REG_DOT_DIV        8'h00
`define REG_FONT_ADDR      8'h04
`define REG_FONT_DATA      8'h08
`define REG_STATUS         8'h0C

// Font geometry
`define FONT_SYMBOLS       128
`define FONT_DOTS          7
`define CODE_W             7
`define ROW_W              4
`define FONT_ADDR_W        11
`define ROW_FIRST          4'h1
`define ROW_LAST           4'hB
`define CARET_ROW_A        4'hA
`define CARET_ROW_B        4'hB
`define CARET_PATTERN      7'h7F

// Case fold: upper code bit forces the next one low
`define CODE_UPPER_BIT     6
`define CODE_CASE_BIT      5

// Status field positions
`define ST_VIDEO_BIT       0
`define ST_SHIFT_LSB       1
`define ST_ROW_LSB         8
`define ST_CODE_LSB        12
`define ST_CASE_BIT        19
`define ST_CARET_BIT       20
`define ST_CLRHOLD_BIT     21

// AXI responses
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

// Timing
`define CLK_MHZ            250
`define DOT_MAX_MHZ        20
`define DOT_MIN_MHZ        1
`define DIV_MIN            ((`CLK_MHZ + `DOT_MAX_MHZ - 1) / `DOT_MAX_MHZ)
`define DIV_MAX            (`CLK_MHZ / `DOT_MIN_MHZ)
`define DIV_RESET          8'h19
`define CODE_TO_LOAD_NS    400
`define ROW_TO_LOAD_NS     1000

`endif

// [src/font_store.v]
// Font memory: one 7-dot word per symbol row, registered read data
`timescale 1ns/100ps
module font_store #(
  parameter AW = 11,
  parameter DW = 7
) (
  input  wire          clk_i,    // System clock
  input  wire          we_i,     // Write strobe
  input  wire [AW-1:0] waddr_i,  // Write address
  input  wire [DW-1:0] wdata_i,  // Write data
  input  wire [AW-1:0] raddr_i,  // Read address
  output reg  [DW-1:0] rdata_o   // Registered read data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule // font_store

// [src/char_rom_video_serializer.v]
// Character generator with video shift register and AXI4-Lite control
`timescale 1ns/100ps
`include "char_gen_defs.vh"
module char_rom_video_serializer (
  input  wire        clk_i,            // 250 MHz system clock
  input  wire        reset_n_i,        // Async reset, active low
  input  wire        row_strobe_i,     // Row capture strobe pin
  input  wire [3:0]  row_select_i,     // Row number pins
  input  wire        code_strobe_i,    // Character capture strobe pin
  input  wire [6:0]  char_code_i,      // Character code pins
  input  wire        case_fold_i,      // Lower case fold pin
  input  wire        caret_overlay_i,  // Cursor overlay pin
  input  wire        parallel_load_i,  // Parallel load pin
  input  wire        force_high_i,     // Force output high pin
  input  wire        force_low_i,      // Force output low pin
  output reg         serial_video_o,   // Serial dot output
  input  wire [7:0]  s_axi_awaddr,     // Write address
  input  wire        s_axi_awvalid,    // Write address valid
  output reg         s_axi_awready,    // Write address ready
  input  wire [31:0] s_axi_wdata,      // Write data
  input  wire [3:0]  s_axi_wstrb,      // Write byte strobes
  input  wire        s_axi_wvalid,     // Write data valid
  output reg         s_axi_wready,     // Write data ready
  output reg  [1:0]  s_axi_bresp,      // Write response
  output reg         s_axi_bvalid,     // Write response valid
  input  wire        s_axi_bready,     // Write response ready
  input  wire [7:0]  s_axi_araddr,     // Read address
  input  wire        s_axi_arvalid,    // Read address valid
  output reg         s_axi_arready,    // Read address ready
  output reg  [31:0] s_axi_rdata,      // Read data
  output reg  [1:0]  s_axi_rresp,      // Read response
  output reg         s_axi_rvalid,     // Read data valid
  input  wire        s_axi_rready      // Read data ready
);

  localparam DIV_LO = `DIV_MIN;
  localparam DIV_HI = `DIV_MAX;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage one is read only by stage two

  localparam SW = 18;
  wire [SW-1:0] pins = {row_strobe_i, row_select_i, code_strobe_i,
                        char_code_i, case_fold_i, caret_overlay_i,
                        parallel_load_i, force_high_i, force_low_i};
  reg  [SW-1:0] sync_a;
  reg  [SW-1:0] sync_b;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_a <= {SW{1'b0}};
      sync_b <= {SW{1'b0}};
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end

  wire       row_stb_s   = sync_b[17];
  wire [3:0] row_sel_s   = sync_b[16:13];
  wire       code_stb_s  = sync_b[12];
  wire [6:0] code_s      = sync_b[11:5];
  wire       fold_s      = sync_b[4];
  wire       caret_s     = sync_b[3];
  wire       load_s      = sync_b[2];
  wire       fhigh_s     = sync_b[1];
  wire       flow_s      = sync_b[0];

  //////////////////////////////////////////////////////////////////////////
  // Holding registers

  reg [3:0] row_hold;
  reg [6:0] code_hold;
  reg       fold_hold;
  reg       caret_hold;

  // Level-sensitive capture: a held-high strobe makes them transparent
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      row_hold   <= 4'h0;
      code_hold  <= 7'h00;
      fold_hold  <= 1'b0;
      caret_hold <= 1'b0;
    end else begin
      if (row_stb_s) begin
        row_hold <= row_sel_s;
      end
      if (code_stb_s) begin
        code_hold  <= code_s;
        fold_hold  <= fold_s;
        caret_hold <= caret_s;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Font addressing and word assembly

  function [6:0] fold_code;
    input [6:0] code;
    input       fold;
    begin
      fold_code = code;
      if (fold && code[`CODE_UPPER_BIT]) begin
        fold_code[`CODE_CASE_BIT] = 1'b0;
      end
    end
  endfunction

  function row_in_font;
    input [3:0] row;
    begin
      row_in_font = (row >= `ROW_FIRST) && (row <= `ROW_LAST);
    end
  endfunction

  wire [6:0]  eff_code  = fold_code(code_hold, fold_hold);
  wire [10:0] font_raddr = {eff_code, row_hold};
  wire [6:0]  font_q;

  reg  [10:0] font_addr;
  reg         font_we;
  reg  [6:0]  font_wdata;
  reg  [10:0] font_waddr;

  font_store #(
    .AW (`FONT_ADDR_W),
    .DW (`FONT_DOTS)
  ) u_font (
    .clk_i   (clk_i),
    .we_i    (font_we),
    .waddr_i (font_waddr),
    .wdata_i (font_wdata),
    .raddr_i (font_raddr),
    .rdata_o (font_q)
  );

  // Blank rows give zero; the cursor lives on the two lowest rows
  wire [6:0] sym_word = row_in_font(row_hold) ? font_q : 7'h00;
  wire       caret_row  = (row_hold == `CARET_ROW_A) ||
                          (row_hold == `CARET_ROW_B);
  wire [6:0] caret_word = (caret_hold && caret_row) ?
                          `CARET_PATTERN : 7'h00;
  wire [6:0] load_word  = sym_word | caret_word;

  //////////////////////////////////////////////////////////////////////////
  // Dot clock divider

  reg [7:0] dot_div;
  reg [7:0] dot_cnt;
  reg       dot_en;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dot_cnt <= 8'h00;
      dot_en  <= 1'b0;
    end else if (dot_cnt >= dot_div - 8'h01) begin
      dot_cnt <= 8'h00;
      dot_en  <= 1'b1;
    end else begin
      dot_cnt <= dot_cnt + 8'h01;
      dot_en  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Video shift register

  reg [6:0] shifter;
  reg       clr_hold;

  // The load keeps shifting blocked, so a held load just reloads
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shifter        <= 7'h00;
      clr_hold       <= 1'b0;
      serial_video_o <= 1'b0;
    end else if (dot_en) begin
      if (load_s) begin
        shifter  <= load_word;
        clr_hold <= flow_s;
      end else begin
        shifter  <= {shifter[5:0], 1'b0};
      end
      if (flow_s || clr_hold) begin
        serial_video_o <= 1'b0;
      end else if (fhigh_s) begin
        serial_video_o <= 1'b1;
      end else if (load_s) begin
        serial_video_o <= serial_video_o;
      end else begin
        serial_video_o <= shifter[6];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire       wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire [7:0] div_in = w_data[7:0];

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      dot_div       <= `DIV_RESET;
      font_addr     <= 11'h000;
      font_we       <= 1'b0;
      font_wdata    <= 7'h00;
      font_waddr    <= 11'h000;
    end else begin
      font_we <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case ({aw_addr[7:2], 2'b00})
          `REG_DOT_DIV: begin
            if (w_strb[0]) begin
              // Clamp keeps the dot rate inside its legal band
              if (div_in < DIV_LO[7:0]) begin
                dot_div <= DIV_LO[7:0];
              end else if (div_in > DIV_HI[7:0]) begin
                dot_div <= DIV_HI[7:0];
              end else begin
                dot_div <= div_in;
              end
            end
          end
          `REG_FONT_ADDR: begin
            if (w_strb[0]) begin
              font_addr[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
              font_addr[10:8] <= w_data[10:8];
            end
          end
          `REG_FONT_DATA: begin
            if (w_strb[0]) begin
              font_we    <= 1'b1;
              font_waddr <= font_addr;
              font_wdata <= w_data[6:0];
              font_addr  <= font_addr + 11'h001;
            end
          end
          `REG_STATUS: begin
            s_axi_bresp <= `RESP_SLVERR;
          end
          default: begin
            s_axi_bresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  reg [31:0] status_word;

  always @* begin
    status_word = 32'h0000_0000;
    status_word[`ST_VIDEO_BIT] = serial_video_o;
    status_word[`ST_SHIFT_LSB +: 7] = shifter;
    status_word[`ST_ROW_LSB +: 4] = row_hold;
    status_word[`ST_CODE_LSB +: 7] = code_hold;
    status_word[`ST_CASE_BIT] = fold_hold;
    status_word[`ST_CARET_BIT] = caret_hold;
    status_word[`ST_CLRHOLD_BIT] = clr_hold;
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
          `REG_DOT_DIV:   s_axi_rdata <= {24'h00_0000, dot_div};
          `REG_FONT_ADDR: s_axi_rdata <= {21'h00_0000, font_addr};
          `REG_FONT_DATA: s_axi_rdata <= 32'h0000_0000;
          `REG_STATUS:    s_axi_rdata <= status_word;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // char_rom_video_serializer

// [test/video_props.sv]
// Port checker for the character generator, bound to its top module
`timescale 1ns/100ps
module video_props (
  input wire logic        clk_i,          // Clock
  input wire logic        reset_n_i,      // Reset, active low
  input wire logic        force_low_i,    // Force zero
  input wire logic        serial_video_o, // Dot out
  input wire logic        s_axi_awvalid,  // AW valid
  input wire logic        s_axi_awready,  // AW ready
  input wire logic        s_axi_wvalid,   // W valid
  input wire logic        s_axi_wready,   // W ready
  input wire logic        s_axi_bvalid,   // B valid
  input wire logic        s_axi_bready,   // B ready
  input wire logic        s_axi_arvalid,  // AR valid
  input wire logic        s_axi_arready,  // AR ready
  input wire logic [7:0]  s_axi_araddr,   // AR address
  input wire logic        s_axi_rvalid,   // R valid
  input wire logic        s_axi_rready,   // R ready
  input wire logic [31:0] s_axi_rdata,    // R data
  input wire logic [1:0]  s_axi_rresp     // R response
);
  logic [8:0] lo_cnt;
  // Long enough for the slowest divider plus pin sync
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lo_cnt <= 9'h000;
    end else begin
      lo_cnt <= !force_low_i ? 9'h000 : lo_cnt + {8'h00, ~&lo_cnt};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_wr_one;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_one: assert property (p_wr_one) else $error("second write taken");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_rd_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0F
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read passed");
  property p_dot_rate;
    $changed(serial_video_o) |=> $stable(serial_video_o) [*8];
  endproperty
  a_dot_rate: assert property (p_dot_rate) else $error("dot too fast");
  property p_low;
    lo_cnt == 9'h104 |-> !serial_video_o;
  endproperty
  a_low: assert property (p_low) else $error("force low ignored");
endmodule // video_props

bind char_rom_video_serializer video_props u_props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .force_low_i(force_low_i),
  .serial_video_o(serial_video_o), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

// [test/video_ctrl.sv]
// Behavioural timing controller driving the generator's video pins
`timescale 1ns/100ps
module video_ctrl #(
  parameter int DIV = 13
) (
  input  wire logic  clk_i,           // Clock
  output logic       row_strobe_o,    // Row capture
  output logic [3:0] row_select_o,    // Row number
  output logic       code_strobe_o,   // Code capture
  output logic [6:0] char_code_o,     // Symbol code
  output logic       case_fold_o,     // Case fold
  output logic       caret_overlay_o, // Cursor overlay
  output logic       parallel_load_o, // Load
  output logic       force_high_o,    // Force one
  output logic       force_low_o      // Force zero
);
  initial begin
    {row_strobe_o, row_select_o, code_strobe_o, char_code_o} = 13'h0000;
    {case_fold_o, caret_overlay_o, parallel_load_o} = 3'h0;
    {force_high_o, force_low_o} = 2'h0;
  end
  task present(input [6:0] c, input [3:0] r, input f, k, lt);
    begin
      {char_code_o, row_select_o, case_fold_o, caret_overlay_o} <=
        lt ? {c, r, f, k} : ~{c, r, f, k};
      code_strobe_o <= 1'b1;
      row_strobe_o  <= 1'b1;
      repeat (DIV) @(posedge clk_i);
      code_strobe_o <= !lt;
      row_strobe_o  <= !lt;
      // Held-high strobes must follow the lines, not keep the first value
      if (!lt) begin
        {char_code_o, row_select_o, case_fold_o, caret_overlay_o} <=
          {c, r, f, k};
      end
      repeat (DIV) @(posedge clk_i);
      // Past hold time the lines carry another value
      if (lt) begin
        {char_code_o, row_select_o, case_fold_o, caret_overlay_o} <=
          ~{c, r, f, k};
      end
      repeat (20 * DIV) @(posedge clk_i);
    end
  endtask
  task load;
    begin
      parallel_load_o <= 1'b1;
      repeat (DIV) @(posedge clk_i);
      parallel_load_o <= 1'b0;
    end
  endtask
  task frc(input h, l);
    begin
      force_high_o <= h;
      force_low_o  <= l;
    end
  endtask
endmodule // video_ctrl

// [test/testbench.sv]
// Self-checking bench for the character generator and dot serializer
`timescale 1ns/100ps
module testbench;
  localparam int DIV = 13;
  logic        clk_i, reset_n_i, serial_video_o;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, rs, cs, cf, co, pl, fh, fl;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  rsel;
  logic [6:0]  code;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          bad_count, checked;
  // Rows 0 and 12 hold dots that must never appear
  logic [6:0]  fw [0:12] = '{7'h7F, 7'h4B, 7'h00, 7'h00, 7'h00, 7'h00,
                             7'h00, 7'h00, 7'h00, 7'h22, 7'h01, 7'h60, 7'h7F};
  video_ctrl #(.DIV(DIV)) ctl (
    .clk_i(clk_i), .row_strobe_o(rs), .row_select_o(rsel),
    .code_strobe_o(cs), .char_code_o(code), .case_fold_o(cf),
    .caret_overlay_o(co), .parallel_load_o(pl), .force_high_o(fh),
    .force_low_o(fl));
  char_rom_video_serializer dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .row_strobe_i(rs),
    .row_select_i(rsel), .code_strobe_i(cs), .char_code_i(code),
    .case_fold_i(cf), .caret_overlay_i(co), .parallel_load_i(pl),
    .force_high_i(fh), .force_low_i(fl), .serial_video_o(serial_video_o),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  ////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] g, e);
    begin
      checked++;
      if (g !== e) begin
        bad_count++;
        $display("mismatch at %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge clk_i);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
        @(posedge clk_i);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    begin
      @(posedge clk_i);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
        @(posedge clk_i);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
    end
  endtask
  // Runs at mid dot period so samples never sit on a tick
  task show(input [6:0] c, input [3:0] r, input f, k, lt, input [6:0] w);
    int i;
    begin
      ctl.present(c, r, f, k, lt);
      ctl.load();
      for (i = 0; i < 9; i++) begin
        repeat (DIV) @(posedge clk_i);
        chk(serial_video_o, (i < 7) ? w[6 - i] : 1'b0);
      end
    end
  endtask
  task t_regs;
    begin
      rd(8'h00, 32'h0000_0019, 2'b00);
      wr(8'h00, 32'h0000_0005, 2'b00);
      rd(8'h00, 32'h0000_000D, 2'b00);
      wr(8'h0C, 32'h0000_0001, 2'b10);
      rd(8'h10, 32'h0000_0000, 2'b10);
      rd(8'h08, 32'h0000_0000, 2'b00);
    end
  endtask
  task t_font;
    int r;
    begin
      wr(8'h04, 32'h0000_0410, 2'b00);
      for (r = 0; r < 13; r++) wr(8'h08, {25'h0, fw[r]}, 2'b00);
      wr(8'h04, 32'h0000_0611, 2'b00);
      wr(8'h08, 32'h0000_003C, 2'b00);
    end
  endtask
  task t_force_high;
    begin
      ctl.frc(1'b1, 1'b0);
      do @(posedge clk_i); while (serial_video_o !== 1'b1);
      repeat (5 + 21 * DIV) @(posedge clk_i);
      chk(serial_video_o, 1'b1);
      ctl.frc(1'b0, 1'b0);
    end
  endtask
  task t_rows;
    begin
      show(7'h41, 4'h1, 1'b0, 1'b0, 1'b1, 7'h4B);
      show(7'h41, 4'hB, 1'b0, 1'b0, 1'b1, 7'h60);
      show(7'h41, 4'h0, 1'b0, 1'b0, 1'b1, 7'h00);
      show(7'h41, 4'hC, 1'b0, 1'b0, 1'b1, 7'h00);
      show(7'h41, 4'hF, 1'b0, 1'b0, 1'b1, 7'h00);
      show(7'h41, 4'hA, 1'b0, 1'b1, 1'b1, 7'h7F);
      show(7'h41, 4'h9, 1'b0, 1'b1, 1'b1, 7'h22);
      show(7'h61, 4'h1, 1'b1, 1'b0, 1'b1, 7'h4B);
      show(7'h61, 4'h1, 1'b0, 1'b0, 1'b0, 7'h3C);
    end
  endtask
  task t_force_low;
    int i;
    begin
      ctl.frc(1'b1, 1'b1);
      repeat (21 * DIV) @(posedge clk_i);
      chk(serial_video_o, 1'b0);
      ctl.frc(1'b0, 1'b1);
      ctl.load();
      ctl.frc(1'b0, 1'b0);
      for (i = 0; i < 7; i++) begin
        repeat (DIV) @(posedge clk_i);
        chk(serial_video_o, 1'b0);
      end
      ctl.load();
      repeat (2 * DIV) @(posedge clk_i);
      chk(serial_video_o, 1'b1);
    end
  endtask
  task finish_test;
    begin
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #60000;
    bad_count++;
    finish_test;
  end
  initial begin
    {reset_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
    s_axi_wdata = 32'h0000_0000;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs;
    t_font;
    t_force_high;
    t_rows;
    t_force_low;
    finish_test;
  end
endmodule // testbench
